//--- gpt_edge.sv
// Edge detector for a pin with optional two-stage synchroniser
`default_nettype none
module gpt_edge
	import gpt_pkg::*;
(
	input  wire logic clk,
	input  wire logic rst,
	input  wire logic pin,
	input  wire logic sync_en,
	output logic      rise,
	output logic      fall
);
	logic sync1_reg;
	logic sync2_reg;
	logic sync3_reg;
	logic direct_reg;
	logic direct_fall;
	logic sync_fall;
	logic direct_rise;
	logic sync_rise;

	// Two-flop synchroniser, third stage for edge history
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sync1_reg  <= 1'b0;
			sync2_reg  <= 1'b0;
			sync3_reg  <= 1'b0;
			direct_reg <= 1'b0;
		end else begin
			sync1_reg  <= pin;
			sync2_reg  <= sync1_reg;
			sync3_reg  <= sync2_reg;
			direct_reg <= pin;
		end
	end

	// Direct path reacts two cycles sooner, synchronised path is safer
	assign direct_rise = pin & ~direct_reg;
	assign direct_fall = ~pin & direct_reg;
	assign sync_rise   = sync2_reg & ~sync3_reg;
	assign sync_fall   = ~sync2_reg & sync3_reg;
	assign rise = sync_en ? sync_rise : direct_rise;
	assign fall = sync_en ? sync_fall : direct_fall;
endmodule : gpt_edge
`default_nettype wire

//--- gpt_pin_src.sv
// Partner model: bursts of pulses on the external clock or gate pin
`default_nettype none
module gpt_pin_src (
	input  wire logic       clk,
	input  wire logic       start,
	input  wire logic [7:0] pulses,
	input  wire logic [7:0] half,
	output logic            pin,
	output logic            busy
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] left     = 8'h00;
	logic [7:0] tcnt     = 8'h00;
	logic       pin_reg  = 1'b0;
	logic       busy_reg = 1'b0;
	// Pin stands low between bursts, so no clock runs outside them
	assign pin  = pin_reg;
	assign busy = busy_reg;
	// Each pulse is half cycles low, then half cycles high
	always @(posedge clk) begin
		if (start && !busy_reg) begin
			busy_reg <= 1'b1;
			left     <= pulses;
			tcnt     <= half;
		end else if (busy_reg) begin
			tcnt <= tcnt - 8'h01;
			if (tcnt == 8'h01) begin
				tcnt    <= half;
				pin_reg <= ~pin_reg;
				if (pin_reg) begin
					left     <= left - 8'h01;
					busy_reg <= (left != 8'h01);
				end
			end
		end
	end
endmodule : gpt_pin_src
`default_nettype wire

//--- gpt_pkg.sv
// Package of constants and types for the gated prescaled timer
`default_nettype none
package gpt_pkg;
	// Register word offsets on the bus
	localparam logic [2:0] GPT_OFS_CTRL   = 3'h0;
	localparam logic [2:0] GPT_OFS_COUNT  = 3'h1;
	localparam logic [2:0] GPT_OFS_PERIOD = 3'h2;
	localparam logic [2:0] GPT_OFS_STATUS = 3'h3;
	localparam logic [2:0] GPT_OFS_MASK   = 3'h4;
	// Control field positions
	localparam int GPT_BIT_ON    = 15;
	localparam int GPT_BIT_IDLE  = 13;
	localparam int GPT_BIT_GATE  = 6;
	localparam int GPT_BIT_PSC   = 4;
	localparam int GPT_BIT_SYNC  = 2;
	localparam int GPT_BIT_SRC   = 1;
	// Status and mask bit positions
	localparam int GPT_ST_MATCH  = 0;
	localparam int GPT_ST_GATE   = 1;
	localparam int GPT_ST_W      = 2;
	// Reset values
	localparam logic [15:0] GPT_RST_COUNT  = 16'h0000;
	localparam logic [15:0] GPT_RST_PERIOD = 16'hffff;
	localparam logic [1:0]  GPT_RST_STATUS = 2'h0;
	localparam logic [1:0]  GPT_RST_MASK   = 2'h0;
	// Prescale terminal counts for 1:1, 1:8, 1:64, 1:256
	localparam logic [7:0]  GPT_PSC_T1   = 8'h00;
	localparam logic [7:0]  GPT_PSC_T8   = 8'h07;
	localparam logic [7:0]  GPT_PSC_T64  = 8'h3f;
	localparam logic [7:0]  GPT_PSC_T256 = 8'hff;

	// Control register fields
	typedef struct packed {
		logic       timer_on;
		logic       idle_stop;
		logic       gated_accumulate;
		logic [1:0] prescale_select;
		logic       ext_clock_sync;
		logic       clock_source_select;
	} gpt_ctrl_type;

	localparam gpt_ctrl_type GPT_RST_CTRL = '{1'b0, 1'b0, 1'b0, 2'h0,
		1'b0, 1'b0};

	// Bus handshake phases
	typedef enum logic {GPT_BUS_IDLE, GPT_BUS_DONE} gpt_bus_type;
endpackage : gpt_pkg
`default_nettype wire

//--- gpt_prescale.sv
// Prescaler that passes one of every 1, 8, 64 or 256 input ticks
`default_nettype none
module gpt_prescale
	import gpt_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       rst,
	input  wire logic       clear,
	input  wire logic       tick_in,
	input  wire logic [1:0] select,
	output logic            tick_out
);
	logic [7:0] cnt_reg;
	logic [7:0] cnt_next;
	logic [7:0] terminal;

	// Terminal count from the ratio field
	assign terminal = (select == 2'h0) ? GPT_PSC_T1 :
		(select == 2'h1) ? GPT_PSC_T8 :
		(select == 2'h2) ? GPT_PSC_T64 : GPT_PSC_T256;
	assign tick_out = tick_in & (cnt_reg >= terminal);
	assign cnt_next = tick_out ? 8'h00 : cnt_reg + 8'h01;

	// Count input ticks, restart on clear
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cnt_reg <= 8'h00;
		end else if (clear) begin
			cnt_reg <= 8'h00;
		end else if (tick_in) begin
			cnt_reg <= cnt_next;
		end
	end
endmodule : gpt_prescale
`default_nettype wire

//--- gpt_timer.sv
// Gated prescaled 16-bit timer with Avalon-MM register slave
// Overview of operation
// - Modes: internal timer, synchronised external counter, direct counter
// - Interrupt on count equal to period, and on gate falling edge
// - Timer may keep running during idle and sleep per configuration
// - Counting only while control bit 15 is one
// - Bit 6 gates internal counting by gate input high; ignored externally
// - Bits 5-4 prescale input by 1, 8, 64 or 256
// - Bit 2 selects synchronised external clock; ignored for internal clock
`default_nettype none
module gpt_timer
	import gpt_pkg::*;
#(
	parameter int WIDTH = 16
)
(
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic [2:0]  address,
	input  wire logic        read,
	input  wire logic        write,
	input  wire logic [31:0] writedata,
	input  wire logic [3:0]  byteenable,
	output logic [31:0]      readdata,
	output logic             waitrequest,
	input  wire logic        ext_clock_pin,
	input  wire logic        cpu_idle,
	input  wire logic        cpu_sleep,
	output logic             irq
);
	gpt_ctrl_type     ctrl_reg;
	logic [WIDTH-1:0] count_reg;
	logic [WIDTH-1:0] count_next;
	logic [WIDTH-1:0] period_reg;
	logic [1:0]       status_reg;
	logic [1:0]       status_next;
	logic [1:0]       clr_mask;
	logic [1:0]       mask_reg;
	gpt_bus_type      bus_reg;
	logic [31:0]      readdata_reg;
	logic [31:0]      rd_mux;
	logic [15:0]      ctrl_word;
	logic             req;
	logic             done;
	logic             wr_fire;
	logic             rd_fire;
	logic             wr_ctrl;
	logic             wr_count;
	logic             wr_period;
	logic             wr_mask;
	logic             rd_status;
	logic [15:0]      wdat;
	logic             ext_mode;
	logic             async_mode;
	logic             pin_rise;
	logic             pin_fall;
	logic             gate_high;
	logic             raw_tick;
	logic             halted;
	logic             run;
	logic             psc_clear;
	logic             tick;
	logic             at_period;
	logic             match_evt;
	logic             gate_evt;

	// Bus handshake: one wait cycle, answer on the second edge
	assign req         = read | write;
	assign done        = (bus_reg == GPT_BUS_DONE);
	assign waitrequest = req & ~done;
	assign wr_fire     = write & done;
	assign rd_fire     = read & done;
	assign readdata    = readdata_reg;

	// Register write decode, low half-word lanes only
	assign wdat = {byteenable[1] ? writedata[15:8] : 8'h00,
		byteenable[0] ? writedata[7:0] : 8'h00};
	assign wr_ctrl   = wr_fire & (address == GPT_OFS_CTRL);
	assign wr_count  = wr_fire & (address == GPT_OFS_COUNT);
	assign wr_period = wr_fire & (address == GPT_OFS_PERIOD);
	assign wr_mask   = wr_fire & (address == GPT_OFS_MASK);
	assign rd_status = rd_fire & (address == GPT_OFS_STATUS);

	// Control register image, unimplemented bits read zero
	assign ctrl_word = {ctrl_reg.timer_on, 1'b0, ctrl_reg.idle_stop,
		6'h00, ctrl_reg.gated_accumulate, ctrl_reg.prescale_select,
		1'b0, ctrl_reg.ext_clock_sync, ctrl_reg.clock_source_select,
		1'b0};

	// Read mux, unmapped offsets read zero
	assign rd_mux =
		(address == GPT_OFS_CTRL)   ? {16'h0000, ctrl_word} :
		(address == GPT_OFS_COUNT)  ? {16'h0000, count_reg} :
		(address == GPT_OFS_PERIOD) ? {16'h0000, period_reg} :
		(address == GPT_OFS_STATUS) ? {30'h0, status_reg} :
		(address == GPT_OFS_MASK)   ? {30'h0, mask_reg} : 32'h0;

	// Handshake phase and read data capture
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			bus_reg      <= GPT_BUS_IDLE;
			readdata_reg <= 32'h0;
		end else begin
			bus_reg      <= (req & ~done) ? GPT_BUS_DONE : GPT_BUS_IDLE;
			if (read & ~done) begin
				readdata_reg <= rd_mux;
			end
		end
	end

	// Control, period and mask registers
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ctrl_reg   <= GPT_RST_CTRL;
			period_reg <= GPT_RST_PERIOD;
			mask_reg   <= GPT_RST_MASK;
		end else begin
			if (wr_ctrl) begin
				ctrl_reg.timer_on            <= wdat[GPT_BIT_ON];
				ctrl_reg.idle_stop           <= wdat[GPT_BIT_IDLE];
				ctrl_reg.gated_accumulate    <= wdat[GPT_BIT_GATE];
				ctrl_reg.prescale_select     <= wdat[GPT_BIT_PSC +: 2];
				ctrl_reg.ext_clock_sync      <= wdat[GPT_BIT_SYNC];
				ctrl_reg.clock_source_select <= wdat[GPT_BIT_SRC];
			end
			if (wr_period) begin
				period_reg <= wdat;
			end
			if (wr_mask) begin
				mask_reg <= wdat[1:0];
			end
		end
	end

	// Pin edge detection, synchroniser used for internal and external sync modes, bypassed only in direct mode
	gpt_edge u_edge (
		.clk     (clk),
		.rst     (rst),
		.pin     (ext_clock_pin),
		.sync_en (ctrl_reg.ext_clock_sync | ~ctrl_reg.clock_source_select),
		.rise    (pin_rise),
		.fall    (pin_fall)
	);

	// Source selection and gating
	assign ext_mode   = ctrl_reg.clock_source_select;
	assign async_mode = ext_mode & ~ctrl_reg.ext_clock_sync;
	assign gate_high  = ext_clock_pin;
	assign raw_tick   = ext_mode ? pin_rise :
		(~ctrl_reg.gated_accumulate | gate_high);

	// Power state halts: idle per bit 13, sleep unless direct counting
	assign halted = (cpu_idle & ctrl_reg.idle_stop) |
		(cpu_sleep & ~async_mode);
	assign run = ctrl_reg.timer_on & ~halted;
	assign psc_clear = ~ctrl_reg.timer_on | wr_ctrl;

	gpt_prescale u_prescale (
		.clk      (clk),
		.rst      (rst),
		.clear    (psc_clear),
		.tick_in  (raw_tick & run),
		.select   (ctrl_reg.prescale_select),
		.tick_out (tick)
	);

	// Period compare and wrap to zero
	assign at_period  = (count_reg == period_reg);
	assign match_evt  = tick & at_period;
	assign count_next = at_period ? '0 : count_reg + 1'b1;

	// Gate falling edge in gated internal mode
	assign gate_evt = ctrl_reg.timer_on & ~ext_mode &
		ctrl_reg.gated_accumulate & pin_fall;

	// Count register, bus write has priority
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			count_reg <= GPT_RST_COUNT;
		end else if (wr_count) begin
			count_reg <= wdat;
		end else if (tick) begin
			count_reg <= count_next;
		end
	end

	// Sticky status; a read clears only the bits that it returned, so
	// an event landing during the access is kept; new event wins
	assign clr_mask    = rd_status ? readdata_reg[1:0] : 2'h0;
	assign status_next = (status_reg & ~clr_mask) |
		{gate_evt, match_evt};

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			status_reg <= GPT_RST_STATUS;
		end else begin
			status_reg <= status_next;
		end
	end

	// Level interrupt from unmasked status
	assign irq = |(status_reg & mask_reg);

	chk_off_stable: assert property (@(posedge clk) disable iff (rst)
		(!ctrl_reg.timer_on && !wr_count) |=> $stable(count_reg))
		else $error("count moved while timer off");

	chk_match_wrap: assert property (@(posedge clk) disable iff (rst)
		(match_evt && !wr_count) |=> (count_reg == '0))
		else $error("count did not wrap on period match");

	chk_match_flag: assert property (@(posedge clk) disable iff (rst)
		match_evt |=> status_reg[GPT_ST_MATCH])
		else $error("period match flag not set");

	chk_gate_flag: assert property (@(posedge clk) disable iff (rst)
		gate_evt |=> (status_reg[GPT_ST_GATE] && (irq || !mask_reg[1])))
		else $error("gate fall flag not set");

	chk_div_one: assert property (@(posedge clk) disable iff (rst)
		(run && !ext_mode && !ctrl_reg.gated_accumulate && !wr_count &&
		ctrl_reg.prescale_select == 2'h0 && !at_period && !wr_ctrl)
		|=> (count_reg == $past(count_reg) + 1'b1))
		else $error("internal 1:1 count not incrementing");

	chk_div_eight: assert property (@(posedge clk) disable iff (rst)
		(tick && ctrl_reg.prescale_select == 2'h1 && !ext_mode &&
		!ctrl_reg.gated_accumulate) |=> !tick [*7])
		else $error("1:8 prescale ticked early");

	chk_gate_hold: assert property (@(posedge clk) disable iff (rst)
		(!ext_mode && ctrl_reg.gated_accumulate && !gate_high) |-> !tick)
		else $error("gated timer counted with gate low");

	chk_idle_halt: assert property (@(posedge clk) disable iff (rst)
		(cpu_idle && ctrl_reg.idle_stop) |-> !tick)
		else $error("timer ran in idle with stop set");

	chk_sleep_halt: assert property (@(posedge clk) disable iff (rst)
		(cpu_sleep && !async_mode) |-> !tick)
		else $error("timer ran in sleep without direct clock");

	chk_ext_edge: assert property (@(posedge clk) disable iff (rst)
		(run && async_mode && ctrl_reg.prescale_select == 2'h0 &&
		ext_clock_pin && !$past(ext_clock_pin)) |-> tick)
		else $error("external rising edge not counted");

	chk_bus_wait: assert property (@(posedge clk) disable iff (rst)
		(req && !done) |-> waitrequest ##1 (!req || !waitrequest))
		else $error("bus answer not after one wait cycle");

	chk_status_clear: assert property (@(posedge clk) disable iff (rst)
		(rd_status && !match_evt && !gate_evt) |=>
		((status_reg & readdata_reg[1:0]) == 2'h0))
		else $error("status not cleared by read");

	// Bus handshake: no stall when idle, answer lasts one cycle
	chk_wait_idle: assert property (@(posedge clk) disable iff (rst)
		!req |-> !waitrequest)
		else $error("waitrequest high with no request");

	chk_done_once: assert property (@(posedge clk) disable iff (rst)
		done |=> !done)
		else $error("bus answer lasted more than one cycle");

	chk_read_hold: assert property (@(posedge clk) disable iff (rst)
		done |=> $stable(readdata_reg))
		else $error("read data changed after the answer");

	// Control and data register writes
	chk_ctrl_on: assert property (@(posedge clk) disable iff (rst)
		(wr_ctrl && wdat[GPT_BIT_ON]) |=> ctrl_reg.timer_on)
		else $error("on bit write not taken");

	chk_ctrl_off: assert property (@(posedge clk) disable iff (rst)
		(wr_ctrl && !wdat[GPT_BIT_ON]) |=> !ctrl_reg.timer_on)
		else $error("off bit write not taken");

	chk_count_load: assert property (@(posedge clk) disable iff (rst)
		wr_count |=> (count_reg == $past(wdat)))
		else $error("count write not taken");

	chk_period_load: assert property (@(posedge clk) disable iff (rst)
		wr_period |=> (period_reg == $past(wdat)))
		else $error("period write not taken");

	// Counting follows the prescaled tick only
	chk_off_no_tick: assert property (@(posedge clk) disable iff (rst)
		!ctrl_reg.timer_on |-> !tick)
		else $error("tick while timer off");

	chk_tick_step: assert property (@(posedge clk) disable iff (rst)
		(tick && !at_period && !wr_count) |=>
		(count_reg == $past(count_reg) + 1'b1))
		else $error("count did not step on tick");

	chk_no_tick_hold: assert property (@(posedge clk) disable iff (rst)
		(!tick && !wr_count) |=> $stable(count_reg))
		else $error("count moved without tick");

	// Tick source per mode at the 1:1 ratio
	chk_int_sync_ign: assert property (@(posedge clk) disable iff (rst)
		(run && !ext_mode && !ctrl_reg.gated_accumulate &&
		ctrl_reg.prescale_select == 2'h0) |-> tick)
		else $error("internal clock not counted every cycle");

	chk_gate_open: assert property (@(posedge clk) disable iff (rst)
		(run && !ext_mode && ctrl_reg.gated_accumulate && gate_high &&
		ctrl_reg.prescale_select == 2'h0) |-> tick)
		else $error("gated timer idle with gate high");

	chk_ext_no_edge: assert property (@(posedge clk) disable iff (rst)
		(ext_mode && !pin_rise) |-> !tick)
		else $error("external mode counted without pin edge");

	chk_idle_run: assert property (@(posedge clk) disable iff (rst)
		(cpu_idle && !ctrl_reg.idle_stop && !cpu_sleep &&
		ctrl_reg.timer_on && !ext_mode && !ctrl_reg.gated_accumulate &&
		ctrl_reg.prescale_select == 2'h0) |-> tick)
		else $error("timer stopped in idle without stop bit");

	chk_sleep_async: assert property (@(posedge clk) disable iff (rst)
		(cpu_sleep && !cpu_idle && ctrl_reg.timer_on && async_mode &&
		ctrl_reg.prescale_select == 2'h0 && pin_rise) |-> tick)
		else $error("direct count stopped in sleep");

	// Sticky status and interrupt
	chk_status_keep: assert property (@(posedge clk) disable iff (rst)
		!rd_status |=>
		((status_reg & $past(status_reg)) == $past(status_reg)))
		else $error("status bit lost without read");

	chk_status_new: assert property (@(posedge clk) disable iff (rst)
		(!match_evt && !gate_evt) |=>
		((status_reg | $past(status_reg)) == $past(status_reg)))
		else $error("status bit set without event");

	chk_match_irq: assert property (@(posedge clk) disable iff (rst)
		(match_evt && mask_reg[GPT_ST_MATCH] && !wr_mask) |=> irq)
		else $error("unmasked match raised no interrupt");
endmodule : gpt_timer
`default_nettype wire

//--- tb.sv
// Testbench for the gated prescaled timer
`default_nettype none
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	import gpt_pkg::*;
	logic        clk;
	logic        rst;
	logic [2:0]  address;
	logic        read;
	logic        write;
	logic [31:0] writedata;
	logic [3:0]  byteenable;
	logic [31:0] readdata;
	logic        waitrequest;
	logic        pin;
	logic        cpu_idle;
	logic        cpu_sleep;
	logic        irq;
	logic        start;
	logic        busy;
	logic [7:0]  pulses;
	logic [7:0]  half;
	logic [31:0] q;
	logic [31:0] prev;
	int          num_errors;
	int          cmp_count;
	int          dv [4] = '{1, 8, 64, 256};
	logic [31:0] cv [4] = '{32'h8046, 32'h8002, 32'h8002, 32'h8006};
	logic        sv [4] = '{1'b0, 1'b0, 1'b1, 1'b1};
	logic [31:0] ev [4] = '{32'ha, 32'ha, 32'ha, 32'h0};

	gpt_timer #(.WIDTH(16)) dut (.clk(clk), .rst(rst), .address(address),
		.read(read), .write(write), .writedata(writedata),
		.byteenable(byteenable), .readdata(readdata),
		.waitrequest(waitrequest), .ext_clock_pin(pin),
		.cpu_idle(cpu_idle), .cpu_sleep(cpu_sleep), .irq(irq));
	gpt_pin_src src (.clk(clk), .start(start), .pulses(pulses),
		.half(half), .pin(pin), .busy(busy));

	// Verdict and end of run
	task automatic conclude;
		$display("Compares %0d mismatches %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : conclude

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			num_errors++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	// One bus access; request held until waitrequest is low at an edge
	task automatic acc(input logic wr, input logic [2:0] a,
		input logic [31:0] d);
		int n;
		n = 0;
		address <= a;
		read <= !wr;
		write <= wr;
		writedata <= d;
		do begin
			@(posedge clk);
			n++;
		end while (waitrequest !== 1'b0 && n < 50);
		q = readdata;
		read <= 1'b0;
		write <= 1'b0;
		if (waitrequest !== 1'b0) begin
			num_errors++;
			conclude();
		end
		@(posedge clk);
	endtask : acc

	task automatic wirq(input logic v);
		int k;
		k = 0;
		while (irq !== v && k < 200) begin
			@(posedge clk);
			k++;
		end
		chk(irq, v);
		if (irq !== v) begin
			conclude();
		end
	endtask : wirq

	task automatic burst(input logic [7:0] n, input logic [7:0] h);
		int k;
		k = 0;
		pulses <= n;
		half <= h;
		start <= 1'b1;
		@(posedge clk);
		start <= 1'b0;
		@(posedge clk);
		while (busy !== 1'b0 && k < 3000) begin
			@(posedge clk);
			k++;
		end
		if (k >= 3000) begin
			num_errors++;
			conclude();
		end
	endtask : burst

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// Main sequence
	initial begin
		rst = 1'b1;
		address = 3'h0;
		read = 1'b0;
		write = 1'b0;
		writedata = 32'h0;
		byteenable = 4'h3;
		cpu_idle = 1'b0;
		cpu_sleep = 1'b0;
		start = 1'b0;
		pulses = 8'h0;
		half = 8'h0;
		num_errors = 0;
		cmp_count = 0;
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		acc(1, 3'h5, 32'hffff);
		for (int i = 0; i < 6; i++) begin
			acc(0, i[2:0], 32'h0);
			chk(q, (i == 2) ? 32'hffff : 32'h0);
		end
		acc(1, GPT_OFS_CTRL, 32'hffff);
		acc(0, GPT_OFS_CTRL, 32'h0);
		chk(q, 32'ha076);
		byteenable <= 4'h1;
		acc(1, GPT_OFS_CTRL, 32'hffff);
		byteenable <= 4'h3;
		acc(0, GPT_OFS_CTRL, 32'h0);
		chk(q, 32'h0076);
		acc(1, GPT_OFS_PERIOD, 32'hffff);
		// Count over a timed window at each prescale ratio
		for (int p = 0; p < 4; p++) begin
			acc(1, GPT_OFS_COUNT, 32'h0);
			acc(1, GPT_OFS_CTRL, 32'h8000 | (p << GPT_BIT_PSC));
			repeat (4 * dv[p] + dv[p] / 2) @(posedge clk);
			acc(1, GPT_OFS_CTRL, 32'h0);
			acc(0, GPT_OFS_COUNT, 32'h0);
			chk(q >= 4 && q <= ((p == 0) ? 8 : 4), 1);
		end
		prev = q;
		repeat (10) @(posedge clk);
		acc(0, GPT_OFS_COUNT, 32'h0);
		chk(q, prev);
		// Period match, wrap and interrupt
		acc(1, GPT_OFS_PERIOD, 32'h3);
		acc(1, GPT_OFS_MASK, 32'h1);
		acc(1, GPT_OFS_COUNT, 32'h0);
		acc(1, GPT_OFS_CTRL, 32'h8000);
		wirq(1'b1);
		for (int i = 0; i < 4; i++) begin
			acc(0, GPT_OFS_COUNT, 32'h0);
			chk(q <= 3, 1);
		end
		acc(1, GPT_OFS_CTRL, 32'h0);
		acc(0, GPT_OFS_STATUS, 32'h0);
		chk(q, 32'h1);
		acc(0, GPT_OFS_STATUS, 32'h0);
		chk(q, 32'h0);
		chk(irq, 1'b0);
		acc(1, GPT_OFS_MASK, 32'h0);
		acc(1, GPT_OFS_CTRL, 32'h8000);
		repeat (20) @(posedge clk);
		chk(irq, 1'b0);
		acc(1, GPT_OFS_CTRL, 32'h0);
		acc(0, GPT_OFS_STATUS, 32'h0);
		chk(q, 32'h1);
		// Gated accumulation and gate falling edge
		acc(1, GPT_OFS_PERIOD, 32'hffff);
		acc(1, GPT_OFS_COUNT, 32'h0);
		acc(1, GPT_OFS_MASK, 32'h2);
		acc(1, GPT_OFS_CTRL, 32'h8040);
		repeat (20) @(posedge clk);
		acc(0, GPT_OFS_COUNT, 32'h0);
		chk(q, 32'h0);
		burst(8'h1, 8'd30);
		wirq(1'b1);
		acc(1, GPT_OFS_CTRL, 32'h0);
		acc(0, GPT_OFS_COUNT, 32'h0);
		chk(q >= 26 && q <= 34, 1);
		acc(0, GPT_OFS_STATUS, 32'h0);
		chk(q, 32'h2);
		acc(1, GPT_OFS_MASK, 32'h0);
		// External clock: sync, async, and in sleep
		for (int i = 0; i < 4; i++) begin
			cpu_sleep <= sv[i];
			acc(1, GPT_OFS_COUNT, 32'h0);
			acc(1, GPT_OFS_CTRL, cv[i]);
			burst(8'd10, 8'd3);
			repeat (6) @(posedge clk);
			acc(1, GPT_OFS_CTRL, 32'h0);
			acc(0, GPT_OFS_COUNT, 32'h0);
			chk(q, ev[i]);
		end
		cpu_sleep <= 1'b0;
		// Idle with and without the idle-stop bit
		cpu_idle <= 1'b1;
		acc(1, GPT_OFS_COUNT, 32'h0);
		acc(1, GPT_OFS_CTRL, 32'ha000);
		repeat (20) @(posedge clk);
		acc(0, GPT_OFS_COUNT, 32'h0);
		chk(q, 32'h0);
		acc(1, GPT_OFS_CTRL, 32'h8000);
		repeat (20) @(posedge clk);
		acc(0, GPT_OFS_COUNT, 32'h0);
		chk(q >= 20 && q <= 32'hff, 1);
		conclude();
	end
endmodule : tb
`default_nettype wire
